/* File: hdl/cmsl_consts.svh */
`ifndef CMSL_CONSTS_SVH
`define CMSL_CONSTS_SVH

// ----------------------------------------
// Frame layout (bit positions in 40-bit word)
// ----------------------------------------
`define CMSL_FRAME_BITS      40
`define CMSL_DATA_LSB        0
`define CMSL_MS_BIT          16
`define CMSL_ADDR_LSB        17
`define CMSL_CLUSTER_LSB     24
`define CMSL_CMD_LSB         28
`define CMSL_CRC_LSB         32
`define CMSL_CRC_POLY        8'h2f
`define CMSL_CRC_INIT        8'h42
`define CMSL_CMD_WRITE       4'h2
`define CMSL_CMD_READ        4'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define CMSL_CLK_HZ          200000000
`define CMSL_TICK_NS         1000000
`define CMSL_TICK_CYC        ((`CMSL_TICK_NS * 200) / 1000)
`define CMSL_IDLE_MS         60000
`define CMSL_LOSS_MS         1000
`define CMSL_CYC_MIN_MS      100
`define CMSL_CYC_MAX_MS      8000
`define CMSL_CYC_ON_MS       1

// ----------------------------------------
// Widths and counts
// ----------------------------------------
`define CMSL_ERRCNT_W        8
`define CMSL_NREGS           8

`endif

/* File: hdl/cmsl_frame_if.sv */
`include "cmsl_consts.svh"
interface cmsl_frame_if;
	logic                          valid;    // One-cycle pulse: frame ended
	logic                          lenOk;    // Exactly 40 bits seen
	logic [`CMSL_FRAME_BITS-1:0]   rxWord;   // Received frame
	logic [`CMSL_FRAME_BITS-1:0]   txWord;   // Frame to shift out next
	logic                          activity; // Pulse on select fall or sampling edge
	modport shifter (output valid, output lenOk, output rxWord, input txWord, output activity);
	modport core    (input valid, input lenOk, input rxWord, output txWord, input activity);
endinterface : cmsl_frame_if

/* File: hdl/cmsl_link.sv */
`include "cmsl_consts.svh"
// ----------------------------------------
// How it works
// R1: SPI slave, four pins, MSB first
// R2: Host starts every transfer
// R3: Reply carries previous request's register
// R4: Frames are exactly 40 bits
// R5: 8-bit CRC guards each frame
// R6: 4-bit command and cluster fields
// R7: 7-bit register address field
// R8: One master/slave origin bit
// R9: 16-bit data field
// R10: Drop wrong-length or bad-CRC frames
// R11: Fault sets flag, bumps counter
// R12: Reset enters normal, regulator on
// R13: Uninitialised, 60 s quiet: idle, regulator off
// R14: Initialised, 1 s quiet: reset, regulator off
// R15: Cyclic mode pulses regulator, 0.1-8 s
// R16: EEPROM disabled after reset
// R17: Enabled EEPROM loads calibration registers
// R18: Host keeps link at most 4 Mbps
// R19: Chip select delimits, edges counted
// R20: CRC, layout, mode are parameters; the layout comes from macros, not parameters
// ----------------------------------------
module cmsl_link #(
	parameter bit       CPOL     = 1'b0,                   // see R20
	parameter bit       CPHA     = 1'b0,
	parameter logic [7:0] CRC_POLY = `CMSL_CRC_POLY,
	parameter logic [7:0] CRC_INIT = `CMSL_CRC_INIT,
	parameter logic [3:0] CLUSTER_ID = 4'h1,
	parameter int       TICK_CYC = `CMSL_TICK_CYC
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Serial link
	input  wire logic        chip_select_n,
	input  wire logic        serClk,
	input  wire logic        serIn,
	output logic             serOut,
	output logic             serOutEn,
	// Configuration
	input  wire logic        initDone,
	input  wire logic        cyclicEn,
	input  wire logic [12:0] cyclicMs,
	input  wire logic        eepromEn,
	// EEPROM load request and data
	input  wire logic        eeLoadValid,
	input  wire logic [6:0]  eeLoadAddr,
	input  wire logic [15:0] eeLoadData,
	// Status
	output logic             comm_regulator_out,
	output logic             comm_error_flag,
	output logic [`CMSL_ERRCNT_W-1:0] commErrCount,
	output logic [15:0]      first_fault_status,
	output logic [1:0]       linkMode,
	output logic             selfReset,
	output logic             eeLoadAck
);
	cmsl_frame_if fr ();

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	cmsl_shifter #(.CPOL(CPOL), .CPHA(CPHA)) u_shift (
		.core_clk     (core_clk),
		.resetn       (resetn),
		.chip_select_n(chip_select_n),
		.serClk       (serClk),
		.serIn        (serIn),
		.serOut       (serOut),
		.serOutEn     (serOutEn),
		.fr           (fr.shifter)
	);

	logic idleTo, lossTo, cycOn;
	cmsl_watchdog #(.TICK_CYC(TICK_CYC)) u_wd (
		.core_clk   (core_clk),
		.resetn     (resetn),
		.activity   (fr.activity),
		.initDone   (initDone),
		.cyclicEn   (cyclicEn),
		.cyclicMs   (cyclicMs),
		.idleTimeout(idleTo),
		.lossTimeout(lossTo),
		.cyclicOn   (cycOn)
	);

	// ----------------------------------------
	// Frame decode
	// ----------------------------------------
	// CRC over the 32 payload bits, MSB first
	function automatic logic [7:0] crcOf(input logic [31:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 31; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crcOf

	wire [39:0] rx      = fr.rxWord;
	wire [7:0]  rxCrc   = rx[`CMSL_CRC_LSB +: 8];                // see R5
	wire [3:0]  rxCmd   = rx[`CMSL_CMD_LSB +: 4];                // see R6
	wire [3:0]  rxClus  = rx[`CMSL_CLUSTER_LSB +: 4];            // see R6
	wire [6:0]  rxAddr  = rx[`CMSL_ADDR_LSB +: 7];               // see R7
	wire        rxMs    = rx[`CMSL_MS_BIT];                      // see R8
	wire [15:0] rxData  = rx[`CMSL_DATA_LSB +: 16];              // see R9
	wire        crcOk   = (crcOf(rx[31:0]) == rxCrc);
	wire        good    = fr.valid && fr.lenOk && crcOk;         // see R4
	wire        bad     = fr.valid && !(fr.lenOk && crcOk);      // see R10
	wire        forUs   = good && rxMs && rxClus == CLUSTER_ID;
	wire        doWrite = forUs && rxCmd == `CMSL_CMD_WRITE;
	wire        doRead  = forUs && rxCmd == `CMSL_CMD_READ;
	wire        eeWrite = eepromEn && eeLoadValid;               // see R16

	// ----------------------------------------
	// Register store and reply
	// ----------------------------------------
	logic [15:0] regs_reg [`CMSL_NREGS];   // Flip-flop register file
	logic [39:0] reply_reg;                // Reply latched on a good read, shifted out next frame
	logic [6:0]  fr_addr;
	assign fr_addr = eeWrite ? eeLoadAddr : rxAddr;

	genvar g;
	generate
		for (g = 0; g < `CMSL_NREGS; g++) begin : gen_reg
			// Calibration loads take the same write path as the link
			always_ff @(posedge core_clk) begin
				if (!resetn) regs_reg[g] <= 16'h0000;
				else if ((eeWrite || doWrite) && fr_addr == 7'(g)) begin
					regs_reg[g] <= eeWrite ? eeLoadData : rxData;   // see R17
				end
			end
		end
	endgenerate

	wire [15:0] rdData = (rxAddr < 7'(`CMSL_NREGS)) ? regs_reg[rxAddr[2:0]] : 16'h0000;
	wire [31:0] rpBody = {rxCmd, CLUSTER_ID, rxAddr, 1'b0, rdData};

	// Reply latches on a good read; host sees it during the next frame
	always_ff @(posedge core_clk) begin
		if (!resetn) reply_reg <= 40'h0;
		else if (doRead) reply_reg <= {crcOf(rpBody), rpBody};   // see R3
	end
	assign fr.txWord = reply_reg;

	// ----------------------------------------
	// Fault flag and counter
	// ----------------------------------------
	// Flag is sticky; only reset clears it, so no event is lost
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			comm_error_flag <= 1'b0;
			commErrCount    <= '0;
		end else if (bad) begin
			comm_error_flag <= 1'b1;                                // see R11
			if (commErrCount != '1) commErrCount <= commErrCount + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) first_fault_status <= 16'h0000;
		else first_fault_status <= {15'h0000, comm_error_flag | bad}; // see R11
	end

	// ----------------------------------------
	// Power mode and regulator
	// ----------------------------------------
	cmsl_pkg::cmsl_mode_t mode_reg, mode_next;
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			cmsl_pkg::CMSL_NORMAL: if (idleTo) mode_next = cmsl_pkg::CMSL_IDLE;        // see R13
			                       else if (initDone) mode_next = cmsl_pkg::CMSL_INIT;
			cmsl_pkg::CMSL_INIT:   if (cyclicEn) mode_next = cmsl_pkg::CMSL_CYCLIC;
			cmsl_pkg::CMSL_CYCLIC: if (!cyclicEn) mode_next = cmsl_pkg::CMSL_INIT;
			cmsl_pkg::CMSL_IDLE:   if (fr.activity) mode_next = cmsl_pkg::CMSL_NORMAL;
			default:               mode_next = cmsl_pkg::CMSL_NORMAL;
		endcase
	end

	// Loss of traffic once initialised forces a self reset
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			mode_reg           <= cmsl_pkg::CMSL_NORMAL;             // see R12
			comm_regulator_out <= 1'b1;                              // see R12
			selfReset          <= 1'b0;
		end else begin
			mode_reg  <= lossTo ? cmsl_pkg::CMSL_NORMAL : mode_next;  // see R14
			// The timeout is a level while the line stays quiet; the forced return to normal
			// mode masks it after the first cycle, so each loss gives one pulse
			selfReset <= lossTo && mode_reg != cmsl_pkg::CMSL_NORMAL; // see R14
			if (lossTo || mode_next == cmsl_pkg::CMSL_IDLE) comm_regulator_out <= 1'b0;
			else if (mode_next == cmsl_pkg::CMSL_CYCLIC) comm_regulator_out <= cycOn; // see R15
			else comm_regulator_out <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			linkMode  <= 2'b00;
			eeLoadAck <= 1'b0;
		end else begin
			linkMode  <= mode_reg;
			eeLoadAck <= eeWrite;
		end
	end
endmodule : cmsl_link

/* File: hdl/cmsl_pkg.sv */
package cmsl_pkg;
	// Link-level power/watchdog mode, Gray along the usual path
	typedef enum logic [1:0] {
		CMSL_NORMAL = 2'b00,
		CMSL_INIT   = 2'b01,
		CMSL_CYCLIC = 2'b11,
		CMSL_IDLE   = 2'b10
	} cmsl_mode_t;
	// Serial shifter frame state
	typedef enum logic [1:0] {
		CMSL_F_WAIT  = 2'b00,
		CMSL_F_SHIFT = 2'b01,
		CMSL_F_DONE  = 2'b11
	} cmsl_frame_t;
endpackage : cmsl_pkg

/* File: hdl/cmsl_shifter.sv */
`include "cmsl_consts.svh"
// ----------------------------------------
// Serial slave shifter, oversampled by core_clk
// ----------------------------------------
module cmsl_shifter #(
	parameter bit CPOL = 1'b0,
	parameter bit CPHA = 1'b0
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       resetn,
	// Link pins
	input  wire logic       chip_select_n,
	input  wire logic       serClk,
	input  wire logic       serIn,
	output logic            serOut,
	output logic            serOutEn,
	// Frame side
	cmsl_frame_if.shifter   fr
);
	logic [1:0] csSync_reg, ckSync_reg, siSync_reg;  // Two-stage synchronisers
	logic       ckLast_reg, csLast_reg;              // Edge detect on synced values
	logic [`CMSL_FRAME_BITS-1:0] rx_reg, tx_reg;     // Shift registers
	logic [6:0] cnt_reg;                             // Edge count, saturates
	logic       valid_reg, lenOk_reg, act_reg;

	wire ckNow   = ckSync_reg[1] ^ CPOL;
	wire lead    = ckNow & ~ckLast_reg;
	wire trail   = ~ckNow & ckLast_reg;
	wire csAct   = ~csSync_reg[1];
	wire sample  = csAct & (CPHA ? trail : lead);
	wire launch  = csAct & (CPHA ? lead : trail);
	wire csFall  = csSync_reg[1] == 1'b0 && csLast_reg;
	wire csRise  = csSync_reg[1] && !csLast_reg;

	// Synchronisers: first stage read only by second
	always_ff @(posedge core_clk) begin
		csSync_reg <= {csSync_reg[0], chip_select_n};
		ckSync_reg <= {ckSync_reg[0], serClk};
		siSync_reg <= {siSync_reg[0], serIn};
	end

	// Frame delimiting and MSB-first shifting
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ckLast_reg <= 1'b0;
			csLast_reg <= 1'b1;
			rx_reg     <= '0;
			tx_reg     <= '0;
			cnt_reg    <= 7'h00;
			valid_reg  <= 1'b0;
			lenOk_reg  <= 1'b0;
			act_reg    <= 1'b0;
		end else begin
			ckLast_reg <= ckNow;
			csLast_reg <= csSync_reg[1];
			valid_reg  <= csRise;                                    // see R19
			act_reg    <= csFall | sample;
			if (csFall) begin
				tx_reg  <= fr.txWord;                                // see R3
				cnt_reg <= 7'h00;
			end else if (sample) begin
				rx_reg  <= {rx_reg[`CMSL_FRAME_BITS-2:0], siSync_reg[1]}; // see R1
				if (cnt_reg != 7'h7f) cnt_reg <= cnt_reg + 7'h01;
			end else if (launch && cnt_reg != 7'h00) begin
				tx_reg  <= {tx_reg[`CMSL_FRAME_BITS-2:0], 1'b0};     // see R1
			end
			if (csRise) lenOk_reg <= (cnt_reg == 7'(`CMSL_FRAME_BITS)); // see R10
		end
	end

	// MSB leads; driver enabled only while selected
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			serOut   <= 1'b0;
			serOutEn <= 1'b0;
		end else begin
			serOut   <= tx_reg[`CMSL_FRAME_BITS-1];
			serOutEn <= csAct;
		end
	end

	assign fr.valid    = valid_reg;
	assign fr.lenOk    = lenOk_reg;
	assign fr.rxWord   = rx_reg;
	assign fr.activity = act_reg;
endmodule : cmsl_shifter

/* File: hdl/cmsl_watchdog.sv */
`include "cmsl_consts.svh"
// ----------------------------------------
// Millisecond tick and communication watchdog
// ----------------------------------------
module cmsl_watchdog #(
	parameter int TICK_CYC = `CMSL_TICK_CYC
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Events
	input  wire logic        activity,
	input  wire logic        initDone,
	input  wire logic        cyclicEn,
	input  wire logic [12:0] cyclicMs,
	// Results
	output logic             idleTimeout,
	output logic             lossTimeout,
	output logic             cyclicOn
);
	logic [31:0] div_reg;   // Tick divider
	logic [16:0] quiet_reg; // Milliseconds without traffic
	logic [12:0] cyc_reg;   // Cyclic period counter
	wire tick = (div_reg == 32'(TICK_CYC - 1));
	wire [12:0] period = (cyclicMs < 13'(`CMSL_CYC_MIN_MS)) ? 13'(`CMSL_CYC_MIN_MS) :
	                     (cyclicMs > 13'(`CMSL_CYC_MAX_MS)) ? 13'(`CMSL_CYC_MAX_MS) : cyclicMs;

	// Divider and counters; traffic restarts the quiet count
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			div_reg   <= '0;
			quiet_reg <= '0;
			cyc_reg   <= '0;
		end else begin
			div_reg <= tick ? 32'h0 : div_reg + 32'h1;
			if (activity) quiet_reg <= '0;
			else if (tick && quiet_reg != 17'h1ffff) quiet_reg <= quiet_reg + 17'h1;
			if (!cyclicEn) cyc_reg <= '0;
			else if (tick) cyc_reg <= (cyc_reg >= period - 13'h1) ? 13'h0 : cyc_reg + 13'h1;
		end
	end

	assign idleTimeout = !initDone && quiet_reg >= 17'(`CMSL_IDLE_MS);  // see R13
	assign lossTimeout = initDone && quiet_reg >= 17'(`CMSL_LOSS_MS);   // see R14
	assign cyclicOn    = cyclicEn && cyc_reg < 13'(`CMSL_CYC_ON_MS);     // see R15
endmodule : cmsl_watchdog

/* File: verif/cmsl_host_model.sv */
`include "cmsl_consts.svh"
// ----------------------------------------
// Host master: starts every frame itself
// ----------------------------------------
module cmsl_host_model (
	output logic     chip_select_n,
	output logic     serClk,
	output logic     serIn,
	input wire logic serOut
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam realtime HALF = 125.0; // 4 Mbps, the ceiling
	// Idle: deselected, clock parked low
	initial begin
		chip_select_n = 1'b1;
		serClk = 1'b0;
		serIn = 1'b0;
	end
	// Frame builder: check byte over the low 32 bits, MSB first
	function automatic logic [39:0] mk(input logic [3:0] cmd, input logic [3:0] cl, input logic [6:0] a,
		input logic ms, input logic [15:0] d);
		logic [31:0] body;
		logic [7:0]  crc;
		body = {cmd, cl, a, ms, d};
		crc = `CMSL_CRC_INIT;
		for (int i = 31; i >= 0; i--) crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ body[i]) ? `CMSL_CRC_POLY : 8'h00);
		return {crc, body};
	endfunction : mk
	// Shift n bits MSB first, capturing the reply on the leading edge
	task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
		rx = '0;
		chip_select_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			serIn = tx[i];
			#HALF serClk = 1'b1;
			rx = {rx[46:0], serOut};
			#HALF serClk = 1'b0;
		end
		#HALF chip_select_n = 1'b1;
		// Released line shows the inverse, never a stale level
		serIn = ~serIn;
		#(4 * HALF);
	endtask : xfer
endmodule : cmsl_host_model

/* File: verif/cmsl_link_props.sv */
`include "cmsl_consts.svh"
// ----------------------------------------
// Port-level checks on the link block
// ----------------------------------------
module cmsl_link_props #(
	parameter int TICK_CYC = 1
) (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        resetn,
	// Inputs watched
	input wire logic        chip_select_n,
	input wire logic        initDone,
	input wire logic        eepromEn,
	input wire logic        eeLoadValid,
	// Outputs watched
	input wire logic        serOutEn,
	input wire logic        comm_regulator_out,
	input wire logic        comm_error_flag,
	input wire logic [`CMSL_ERRCNT_W-1:0] commErrCount,
	input wire logic [15:0] first_fault_status,
	input wire logic [1:0]  linkMode,
	input wire logic        selfReset,
	input wire logic        eeLoadAck
);
	localparam int EW = `CMSL_ERRCNT_W; // Counter width
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Reset is sampled on release, so this one survives the disable
	a_reset_state: assert property ($rose(resetn) |-> comm_regulator_out && linkMode == 2'h0
		&& !comm_error_flag && commErrCount == '0 && !serOutEn) else $error("state after reset wrong");
	a_flag_status: assert property (first_fault_status[0] == comm_error_flag)
		else $error("status bit and flag differ");
	a_flag_sticky: assert property (comm_error_flag |=> comm_error_flag)
		else $error("error flag dropped");
	// Guard with past reset: a mid-run reset clears the count
	a_count_step: assert property ($past(resetn) && $changed(commErrCount) |->
		EW'(commErrCount - $past(commErrCount)) == EW'(1) && comm_error_flag) else $error("count step wrong");
	a_oe_select: assert property ($fell(chip_select_n) |-> ##[1:4] serOutEn)
		else $error("output not enabled on select");
	a_oe_idle: assert property (chip_select_n [*6] |-> !serOutEn)
		else $error("output enabled while deselected");
	a_ee_ack: assert property (eeLoadValid && eepromEn |=> eeLoadAck)
		else $error("load not acknowledged");
	a_ee_gate: assert property (eeLoadAck |-> $past(eeLoadValid && eepromEn))
		else $error("load taken while disabled");
	a_loss_pulse: assert property (selfReset |-> $past(initDone) ##1 !selfReset)
		else $error("self reset pulse wrong");
	// Mode shows one cycle after the regulator moves, so compare with its previous value
	a_idle_off: assert property (linkMode == 2'h2 |-> !$past(comm_regulator_out))
		else $error("regulator on in idle");
	// Main scenarios reached
	cover property ($rose(comm_error_flag));
	cover property (eeLoadAck);
	cover property (selfReset);
	cover property (linkMode == 2'h2);
endmodule : cmsl_link_props

bind cmsl_link cmsl_link_props #(.TICK_CYC(TICK_CYC)) u_cmsl_link_props (.core_clk, .resetn,
	.chip_select_n, .initDone, .eepromEn, .eeLoadValid, .serOutEn, .comm_regulator_out,
	.comm_error_flag, .commErrCount, .first_fault_status, .linkMode, .selfReset, .eeLoadAck);

/* File: verif/tb.sv */
`include "cmsl_consts.svh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        core_clk, resetn, chip_select_n, serClk, serIn, serOut, serOutEn;
	logic        initDone, cyclicEn, eepromEn, eeLoadValid, eeLoadAck, selfReset;
	logic        comm_regulator_out, comm_error_flag;
	logic [12:0] cyclicMs;
	logic [6:0]  eeLoadAddr;
	logic [15:0] eeLoadData, first_fault_status;
	logic [1:0]  linkMode;
	logic [`CMSL_ERRCNT_W-1:0] commErrCount;
	logic [47:0] rx;           // Last reply word
	int          miscompares;  // Mismatch count
	int          numChecks;    // Comparison count
	// One tick per cycle keeps the 60 s watchdog short
	cmsl_link #(.TICK_CYC(1)) u_cmsl_link (.core_clk, .resetn, .chip_select_n, .serClk, .serIn, .serOut,
		.serOutEn, .initDone, .cyclicEn, .cyclicMs, .eepromEn, .eeLoadValid, .eeLoadAddr, .eeLoadData,
		.comm_regulator_out, .comm_error_flag, .commErrCount, .first_fault_status, .linkMode, .selfReset,
		.eeLoadAck);
	cmsl_host_model u_cmsl_host_model (.chip_select_n, .serClk, .serIn, .serOut);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		numChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude();
		if (miscompares == 0 && numChecks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude
	// Link edges start off the core edge, so the pin synchronisers never race them
	task automatic send(input logic [47:0] w, input int n);
		@(negedge core_clk);
		u_cmsl_host_model.xfer(w, n, rx);
	endtask : send
	task automatic frame(input logic [3:0] cmd, input logic [3:0] cl, input logic [6:0] a, input logic [15:0] d);
		send({8'h00, u_cmsl_host_model.mk(cmd, cl, a, 1'b1, d)}, 40);
	endtask : frame
	// Reply to a read: slave origin bit clear
	function automatic logic [39:0] rep(input logic [6:0] a, input logic [15:0] d);
		return u_cmsl_host_model.mk(4'h1, 4'h1, a, 1'b0, d);
	endfunction : rep
	task automatic ee(input logic en, input logic [15:0] d);
		@(posedge core_clk);
		eepromEn <= en;
		eeLoadValid <= 1'b1;
		eeLoadAddr <= 7'h05;
		eeLoadData <= d;
		@(posedge core_clk);
		eeLoadValid <= 1'b0;
		#1 check("ee ack", eeLoadAck, en);
	endtask : ee
	task automatic waitFor(input int lim, output int n);
		n = 0;
		while (n < lim && !(lim > 2000 ? linkMode === 2'h2 : selfReset === 1'b1)) begin
			@(negedge core_clk);
			n++;
		end
	endtask : waitFor
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		@(negedge core_clk);
		check("regulator", comm_regulator_out, 1'h1);
		check("mode", linkMode, 2'h0);
		check("count", commErrCount, 8'h00);
	endtask : t_reset
	task automatic t_wr();
		frame(4'h2, 4'h1, 7'h03, 16'ha5c3);
		frame(4'h2, 4'h1, 7'h07, 16'h1234);
		frame(4'h1, 4'h1, 7'h03, 16'h0000);
		frame(4'h1, 4'h1, 7'h07, 16'h0000);
		check("reply reg3", rx[39:0], rep(7'h03, 16'ha5c3));
		frame(4'h1, 4'h1, 7'h00, 16'h0000);
		check("reply reg7", rx[39:0], rep(7'h07, 16'h1234));
	endtask : t_wr
	task automatic t_bad();
		logic [39:0] f;
		f = u_cmsl_host_model.mk(4'h2, 4'h1, 7'h03, 1'b1, 16'h0000);
		send({8'h00, ~f[39:32], f[31:0]}, 40);
		frame(4'h2, 4'h2, 7'h03, 16'h0000);
		send({8'h00, f}, 39);
		send({8'h00, f}, 41);
		check("count", commErrCount, 8'h03);
		check("status", first_fault_status[0], 1'h1);
		check("flag", comm_error_flag, 1'h1);
		frame(4'h1, 4'h1, 7'h03, 16'h0000);
	endtask : t_bad
	task automatic t_ee();
		ee(1'b0, 16'h0bad);
		ee(1'b1, 16'hbeef);
		frame(4'h1, 4'h1, 7'h05, 16'h0000);
		check("reg3 kept", rx[39:0], rep(7'h03, 16'ha5c3));
		frame(4'h1, 4'h1, 7'h00, 16'h0000);
		check("reg5 loaded", rx[39:0], rep(7'h05, 16'hbeef));
	endtask : t_ee
	task automatic t_cyc();
		int on;
		on = 0;
		@(posedge core_clk);
		initDone <= 1'b1;
		cyclicEn <= 1'b1;
		cyclicMs <= 13'h0032;
		// Cyclic mode is reached only once initialised; the frame holds off the loss timer
		frame(4'h1, 4'h1, 7'h00, 16'h0000);
		check("cyclic mode", linkMode, 2'h3);
		// Period clamps to 100 ticks, so exactly five one-tick bursts in 500 ticks
		repeat (500) begin
			@(negedge core_clk);
			on += int'(comm_regulator_out === 1'b1);
		end
		check("cyclic bursts", 40'(on), 40'h5);
		@(posedge core_clk);
		cyclicEn <= 1'b0;
	endtask : t_cyc
	task automatic t_wd();
		int n;
		initDone <= 1'b1;
		frame(4'h1, 4'h1, 7'h00, 16'h0000);
		// Last bit was sampled 150 cycles before the count starts
		waitFor(1100, n);
		check("loss time", 40'(n > 830 && n < 870), 1'h1);
		check("loss regulator", comm_regulator_out, 1'h0);
		@(posedge core_clk);
		initDone <= 1'b0;
		frame(4'h1, 4'h1, 7'h00, 16'h0000);
		waitFor(61000, n);
		check("idle time", 40'(n > 59830 && n < 59870), 1'h1);
		repeat (2) @(negedge core_clk);
		check("idle regulator", comm_regulator_out, 1'h0);
		// Any traffic wakes the link back to normal with the regulator on
		frame(4'h1, 4'h1, 7'h00, 16'h0000);
		check("wake mode", linkMode, 2'h0);
		check("wake regulator", comm_regulator_out, 1'h1);
	endtask : t_wd
	// ----------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		// A clean run ends near 477 us; this leaves a margin and stays near 100k cycles
		#520000;
		miscompares++;
		conclude();
	end
	initial begin
		{resetn, initDone, cyclicEn, eepromEn, eeLoadValid} = 5'h00;
		{cyclicMs, eeLoadAddr, eeLoadData} = 36'h000000000;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_reset();
		t_wr();
		t_bad();
		t_ee();
		t_cyc();
		t_wd();
		conclude();
	end
endmodule : tb
